// [rtl/bpd_pkg.sv]
// package: register map, field layout, reset values and carrier types for the power-down control block
package bpd_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int BPD_ADDR_W = 8;
  localparam int BPD_DATA_W = 16;
  localparam logic [BPD_ADDR_W-1:0] BPD_POWER_DOWN_CONTROL_ADDR = 8'h08;
  localparam int BPD_TOUCH_PD_BIT = 0;
  localparam int BPD_KEYPAD_PD_BIT = 1;
  localparam logic [BPD_DATA_W-1:0] BPD_POWER_DOWN_CONTROL_RST = 16'h0000;
  localparam logic [BPD_DATA_W-1:0] BPD_POWER_DOWN_CONTROL_MASK = 16'h0003;
  localparam logic [BPD_DATA_W-1:0] BPD_READ_ZERO = 16'h0000;

  // ****************************************
  // keypad and panel widths
  // ****************************************
  localparam int BPD_NUM_COLUMNS = 6;
  localparam int BPD_KEYDATA_W = 16;
  localparam int BPD_NUM_SWITCHES = 4;
  localparam logic [BPD_KEYDATA_W-1:0] BPD_KEYDATA_EMPTY = 16'h0000;

  // register port request, one access per cycle
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [BPD_ADDR_W-1:0] addr;
    logic [BPD_DATA_W-1:0] wdata;
  } bpd_reg_req_t;

  // register port answer
  typedef struct packed {
    logic rd_valid;
    logic hit;
    logic [BPD_DATA_W-1:0] rdata;
  } bpd_reg_rsp_t;

endpackage

// [rtl/bpd_block_power_down_control.sv]
// module: power-down control register and the gating it applies to touch and keypad blocks
module bpd_block_power_down_control #(
  parameter int NUM_COLUMNS = bpd_pkg::BPD_NUM_COLUMNS,
  parameter int NUM_SWITCHES = bpd_pkg::BPD_NUM_SWITCHES
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // register port from the serial interface
  input wire bpd_pkg::bpd_reg_req_t reg_req_i,
  output bpd_pkg::bpd_reg_rsp_t reg_rsp_o,
  // touch block
  input wire logic [NUM_SWITCHES-1:0] panel_switch_req_i,
  input wire logic pen_detect_i,
  output logic [NUM_SWITCHES-1:0] panel_switch_o,
  output logic pen_detect_en_o,
  output logic pen_interrupt_out_n_o,
  // keypad scanner
  input wire logic [NUM_COLUMNS-1:0] scan_columns_req_i,
  input wire logic key_event_i,
  input wire logic key_data_load_i,
  input wire logic [bpd_pkg::BPD_KEYDATA_W-1:0] key_data_i,
  output logic [NUM_COLUMNS-1:0] scan_column_outputs_o,
  output logic scan_enable_o,
  output logic key_interrupt_out_n_o,
  output logic [bpd_pkg::BPD_KEYDATA_W-1:0] keypad_data_first_o,
  output logic [bpd_pkg::BPD_KEYDATA_W-1:0] keypad_data_second_o,
  // power-down state
  output logic touch_power_down_o,
  output logic keypad_power_down_o
);
  import bpd_pkg::*;

  // elaboration-time refusal of widths the gating cannot serve
  if (NUM_COLUMNS < 1 || NUM_SWITCHES < 1) begin : g_bad_width
    $error("bpd: widths must be at least one");
  end

  // ****************************************
  // register decode
  // ****************************************
  logic [BPD_DATA_W-1:0] pdc_reg;
  logic [BPD_DATA_W-1:0] pdc_next;
  wire addr_hit = (reg_req_i.addr == BPD_POWER_DOWN_CONTROL_ADDR);
  wire wr_hit = reg_req_i.wr_en & addr_hit;
  wire rd_hit = reg_req_i.rd_en & addr_hit;
  assign pdc_next = wr_hit ? (reg_req_i.wdata & BPD_POWER_DOWN_CONTROL_MASK) : pdc_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pdc_reg <= BPD_POWER_DOWN_CONTROL_RST;
    end else begin
      pdc_reg <= pdc_next;
    end
  end

  wire touch_pd = pdc_reg[BPD_TOUCH_PD_BIT];
  wire keypad_pd = pdc_reg[BPD_KEYPAD_PD_BIT];
  assign touch_power_down_o = touch_pd;
  assign keypad_power_down_o = keypad_pd;

  // read answer, registered; unmapped address reads zero with hit low
  bpd_reg_rsp_t rsp_reg;
  bpd_reg_rsp_t rsp_next;
  assign rsp_next.rd_valid = reg_req_i.rd_en;
  assign rsp_next.hit = addr_hit;
  assign rsp_next.rdata = rd_hit ? (pdc_reg & BPD_POWER_DOWN_CONTROL_MASK) : BPD_READ_ZERO;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end
  assign reg_rsp_o = rsp_reg;

  // ****************************************
  // touch block gating
  // ****************************************
  logic [NUM_SWITCHES-1:0] sw_reg;
  logic pen_n_reg;
  wire [NUM_SWITCHES-1:0] sw_next = touch_pd ? '0 : panel_switch_req_i;
  wire pen_n_next = touch_pd ? 1'b1 : ~pen_detect_i;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sw_reg <= '0;
      pen_n_reg <= 1'b1;
    end else begin
      sw_reg <= sw_next;
      pen_n_reg <= pen_n_next;
    end
  end
  // combinational override so power-down takes hold in the same cycle the bit sets
  assign panel_switch_o = touch_pd ? '0 : sw_reg;
  assign pen_detect_en_o = ~touch_pd;
  assign pen_interrupt_out_n_o = touch_pd | pen_n_reg;

  // ****************************************
  // keypad scanner gating
  // ****************************************
  logic [NUM_COLUMNS-1:0] col_reg;
  logic key_n_reg;
  logic [BPD_KEYDATA_W-1:0] kd_first_reg;
  logic [BPD_KEYDATA_W-1:0] kd_second_reg;
  wire [NUM_COLUMNS-1:0] col_next = keypad_pd ? '0 : scan_columns_req_i;
  wire key_n_next = keypad_pd ? 1'b1 : ~key_event_i;
  wire kd_load = key_data_load_i & ~keypad_pd;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      col_reg <= '0;
      key_n_reg <= 1'b1;
    end else begin
      col_reg <= col_next;
      key_n_reg <= key_n_next;
    end
  end

  // second slot holds the older entry; a new load shifts the first into it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || keypad_pd) begin
      kd_first_reg <= BPD_KEYDATA_EMPTY;
      kd_second_reg <= BPD_KEYDATA_EMPTY;
    end else if (kd_load) begin
      kd_second_reg <= kd_first_reg;
      kd_first_reg <= key_data_i;
    end
  end

  assign scan_column_outputs_o = keypad_pd ? '0 : col_reg;
  assign scan_enable_o = ~keypad_pd;
  assign key_interrupt_out_n_o = keypad_pd | key_n_reg;
  assign keypad_data_first_o = kd_first_reg;
  assign keypad_data_second_o = kd_second_reg;

endmodule // bpd_block_power_down_control

// [tb/bpd_chk_chk.sv]
// checker: port assertions of the power-down control block
module bpd_chk import bpd_pkg::*; #(parameter int NUM_COLUMNS = 6, parameter int NUM_SWITCHES = 4) (
  input wire logic clk_sys_i, rst_n_i, touch_power_down_o, keypad_power_down_o,
  input wire logic pen_interrupt_out_n_o, pen_detect_en_o, scan_enable_o, key_interrupt_out_n_o,
  input wire bpd_reg_req_t reg_req_i,
  input wire bpd_reg_rsp_t reg_rsp_o,
  input wire logic [NUM_SWITCHES-1:0] panel_switch_o,
  input wire logic [NUM_COLUMNS-1:0] scan_column_outputs_o,
  input wire logic [15:0] keypad_data_first_o, keypad_data_second_o
);
  timeunit 1ns/1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire wr_hit = reg_req_i.wr_en && reg_req_i.addr == BPD_POWER_DOWN_CONTROL_ADDR;
  AST_SW_OPEN: assert property (touch_power_down_o |-> panel_switch_o == '0) else $error("switch");
  AST_PEN_OFF: assert property (touch_power_down_o |-> pen_interrupt_out_n_o && !pen_detect_en_o) else $error("pen");
  AST_COL_LOW: assert property (keypad_power_down_o |-> scan_column_outputs_o == '0) else $error("column");
  AST_KEY_CLR: assert property (keypad_power_down_o |-> !scan_enable_o ##1
    keypad_data_first_o == '0 && keypad_data_second_o == '0) else $error("keypad data");
  AST_KEY_RUN: assert property (!keypad_power_down_o |-> scan_enable_o) else $error("scan held");
  AST_KEY_IRQ: assert property (keypad_power_down_o |-> key_interrupt_out_n_o) else $error("key irq");
  AST_WR_BITS: assert property (wr_hit |=>
    {keypad_power_down_o, touch_power_down_o} == $past(reg_req_i.wdata[1:0])) else $error("bits");
  AST_RD_RSV: assert property (reg_req_i.rd_en |=> reg_rsp_o.rd_valid && reg_rsp_o.rdata[15:2] == '0)
    else $error("read");
  cover property (touch_power_down_o && keypad_power_down_o);
  cover property (reg_rsp_o.rd_valid && !reg_rsp_o.hit);
  cover property ($fell(keypad_power_down_o));
endmodule // bpd_chk
bind bpd_block_power_down_control bpd_chk #(.NUM_COLUMNS(NUM_COLUMNS), .NUM_SWITCHES(NUM_SWITCHES)) i_chk (.*);

// [tb/bpd_host.sv]
// host model: one-cycle accesses on the register port
module bpd_host import bpd_pkg::*; (
  input wire logic clk_sys_i,
  output bpd_reg_req_t req_o
);
  timeunit 1ns/1ps;
  initial req_o = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i) #1 req_o <= {w, !w, a, d};
    @(posedge clk_sys_i) #1 req_o <= {2'b00, ~a, ~d};
  endtask
endmodule // bpd_host

// [tb/tb.sv]
// testbench: every power-down setting under random pin traffic
module tb;
  timeunit 1ns/1ps;
  import bpd_pkg::*;
  logic clk_sys_i = 0, rst_n_i = 0, pen_detect_i = 0, key_event_i = 0, key_data_load_i = 0;
  logic [3:0] panel_switch_req_i = '0, panel_switch_o;
  logic [5:0] scan_columns_req_i = '0, scan_column_outputs_o;
  logic [15:0] key_data_i = '0, keypad_data_first_o, keypad_data_second_o, v;
  logic pen_detect_en_o, pen_interrupt_out_n_o, scan_enable_o, key_interrupt_out_n_o;
  logic touch_power_down_o, keypad_power_down_o;
  bpd_reg_req_t reg_req_i;
  bpd_reg_rsp_t reg_rsp_o;
  int seed = 78983, miscompares = 0, samples_checked = 0;
  bpd_host i_host (.clk_sys_i(clk_sys_i), .req_o(reg_req_i));
  bpd_block_power_down_control i_dut (.*);
  initial forever #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) #1 {panel_switch_req_i, pen_detect_i, scan_columns_req_i, key_event_i,
    key_data_load_i, key_data_i} <= 29'($random(seed));
  function automatic logic [15:0] exp_rd(input logic [15:0] w);
    return w & BPD_POWER_DOWN_CONTROL_MASK;
  endfunction
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000 miscompares++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    #1 rst_n_i = 1;
    chk({keypad_power_down_o, touch_power_down_o}, 40'h0);
    for (int i = 0; i < 6; i++) begin
      v = 16'($random(seed));
      v[1:0] = i[1:0];
      i_host.acc(1, 8'h08, v);
      i_host.acc(1, 8'h09, ~v);
      i_host.acc(0, 8'h08, 16'h0000);
      chk({reg_rsp_o.rd_valid, reg_rsp_o.hit, reg_rsp_o.rdata}, {2'b11, exp_rd(v)});
      chk({keypad_power_down_o, touch_power_down_o}, v[1:0]);
      if (v[0]) chk({panel_switch_o, pen_interrupt_out_n_o, pen_detect_en_o}, 40'h2);
      else chk({panel_switch_o, pen_interrupt_out_n_o, pen_detect_en_o}, {panel_switch_req_i, ~pen_detect_i, 1'b1});
      if (v[1]) chk({scan_enable_o, scan_column_outputs_o, key_interrupt_out_n_o, keypad_data_first_o,
        keypad_data_second_o}, 40'h0100000000);
      else chk({scan_enable_o, scan_column_outputs_o, key_interrupt_out_n_o}, {1'b1, scan_columns_req_i, ~key_event_i});
      if (!v[1] && key_data_load_i) chk(keypad_data_first_o, key_data_i);
      i_host.acc(0, 8'h09, 16'h0000);
      chk({reg_rsp_o.rd_valid, reg_rsp_o.hit, reg_rsp_o.rdata}, 40'h0000020000);
      $display("test %0d done", i);
    end
    close_out;
  end
endmodule // tb
